// ===== tsrf_pkg.sv
/*
  tsrf_pkg: byte map, field positions, reset values and timing constants of the
  temperature sensor register file.
  assumes: a 250 MHz system clock; the analogue front end delivers a signed result
  in 0.0625 degC units.
*/
`default_nettype none

package tsrf_pkg;

  // ----------------------------------------------------------------
  // byte map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TEMP_RESULT_LOW = 4'h0;
  localparam logic [3:0] ADDR_TEMP_RESULT_HIGH = 4'h1;
  localparam logic [3:0] ADDR_LIMIT_AND_LOCATION_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_OPERATING_SETUP = 4'h3;
  localparam logic [3:0] ADDR_UPPER_LIMIT_HIGH_BYTE = 4'h4;
  localparam logic [3:0] ADDR_UPPER_LIMIT_LOW_BYTE = 4'h5;
  localparam logic [3:0] ADDR_LOWER_LIMIT_LOW_BYTE = 4'h6;
  localparam logic [3:0] ADDR_LOWER_LIMIT_HIGH_BYTE = 4'h7;
  localparam logic [3:0] ADDR_MAP_CHECK_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SETUP_FORMAT_BIT = 7;
  localparam int SETUP_RES_HI_BIT = 6;
  localparam int SETUP_RES_LO_BIT = 5;
  localparam int SETUP_INT_MODE_BIT = 4;
  localparam int SETUP_RESERVED_BIT = 3;
  localparam int SETUP_RATE_HI_BIT = 2;
  localparam int SETUP_RATE_LO_BIT = 0;
  localparam int FLAGS_OVER_BIT = 7;
  localparam int FLAGS_UNDER_BIT = 6;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] TEMP_RESULT_RESET = 16'h0550;
  localparam logic [7:0] OPERATING_SETUP_RESET = 8'h70;
  localparam logic [15:0] UPPER_LIMIT_RESET = 16'h0800;
  localparam logic [15:0] LOWER_LIMIT_RESET = 16'hFC90;
  localparam logic [5:0] LOCATION_RESET = 6'h00;

  // ----------------------------------------------------------------
  // result clamps and resolution codes
  // ----------------------------------------------------------------
  localparam logic signed [15:0] NORMAL_MAX = 16'sh07FF;
  localparam logic signed [15:0] NORMAL_MIN = 16'shF800;
  localparam logic signed [15:0] EXTENDED_MAX = 16'sh0FFF;
  localparam logic signed [15:0] EXTENDED_MIN = 16'shF000;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_9 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] RES_12 = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_MHZ = 250;
  localparam longint CONV10_TIME_US = 35000;
  localparam longint RATE_BASE_TIME_US = 125000;
  localparam logic [31:0] CONV10_CYCLES = 32'(CONV10_TIME_US * CLK_MHZ);
  localparam logic [31:0] RATE_BASE_CYCLES = 32'(RATE_BASE_TIME_US * CLK_MHZ);
  localparam logic [9:0] TICKS_RATE1 = 10'h200;
  localparam logic [9:0] TICKS_RATE2 = 10'h100;
  localparam logic [9:0] TICKS_RATE3 = 10'h080;
  localparam logic [9:0] TICKS_RATE4 = 10'h020;
  localparam logic [9:0] TICKS_RATE5 = 10'h008;
  localparam logic [9:0] TICKS_RATE6 = 10'h002;
  localparam logic [9:0] TICKS_RATE7 = 10'h001;

  // ----------------------------------------------------------------
  // check byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8C;

endpackage

`default_nettype wire

// ===== tsrf_crc8.sv
/*
  tsrf_crc8: check byte over the first eight bytes of the map, least significant
  bit of byte 0 first, shift register starting from zero.
  assumes: the map bytes are stable registers; the result is registered.
*/
`timescale 1ns/10ps
`default_nettype none

module tsrf_crc8 (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [63:0] i_map_bytes,
  output logic [7:0] o_crc
);

  logic [7:0] crc;
  logic [7:0] next_crc;

  // ----------------------------------------------------------------
  // bit-serial polynomial, unrolled by a loop
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (acc[0] ^ i_map_bytes[i]) begin
        acc = (acc >> 1) ^ tsrf_pkg::CRC_POLY_REFLECTED; // [R25]
      end else begin
        acc = acc >> 1;
      end
    end
    next_crc = acc;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      crc <= 8'h00;
    end else if (i_clk_en) begin
      crc <= next_crc;
    end
  end

  assign o_crc = crc;

endmodule // tsrf_crc8

`default_nettype wire

// ===== tsrf_core.sv
/*
  tsrf_core: nine-byte register map, conversion sequencing, result formatting and
  alarm handling of the temperature sensor.
  assumes: the serial bus front end turns accesses into byte read/write strobes and
  command pulses; the analogue front end supplies a live signed result and a
  measured location resistor code; all inputs are synchronous to i_clk_sys.
*/
// Operation
// R1: nine bytes; 0-2 and 8 read only, 3-7 writable; temperature resets to +85.
// R2: result low byte at address 0, high byte at address 1.
// R3: normal format two's complement, bits 15-11 sign, max 128 minus one LSB.
// R4: extended format bit 11 weighs 128, sign only in bits 15-12.
// R5: setup bit 7 selects format, 0 normal, 1 extended, reset 0.
// R6: format change takes effect at the end of the next full conversion.
// R7: master writes limits in the currently selected format; no conversion done.
// R8: flags byte: over in bit 7, under in bit 6, location 5-0, reset zero.
// R9: location bits load only on locate command: resistor code 4-0, strap bit 5.
// R10: setup bits 6-5 pick 8, 9, 10 or 12 bits; default 12.
// R11: conversion time doubles per added bit; 35 ms at 10 bits.
// R12: comparator mode: outside limits asserts alarm and matching flag.
// R13: comparator mode: result within limits inclusive clears alarm and flags.
// R14: interrupt mode: alarm and flags latch until any register is read.
// R15: interrupt mode: a later violating result sets alarm and flags again.
// R16: alarm pin driven only on external supply.
// R17: master keeps rate bits at 000 when bus powered.
// R18: rate 000: start command runs one conversion then returns to shutdown.
// R19: nonzero rate: start command begins repeated conversions at that rate.
// R20: writing the rate field changes rate at once; 000 stops repeats.
// R21: master avoids highest rate together with 12-bit resolution.
// R22: each automatic conversion end updates the temperature bytes.
// R23: bus powered: rate ignored, standby until start command.
// R24: limits use the same 16-bit format as the result.
// R25: byte 8 holds check byte over bytes 0-7, refreshed on change.
// R26: each result compared signed against both limits before flags update.
`timescale 1ns/10ps
`default_nettype none

module tsrf_core #(
  parameter logic [31:0] CONV10_CYCLES = tsrf_pkg::CONV10_CYCLES,
  parameter logic [31:0] RATE_BASE_CYCLES = tsrf_pkg::RATE_BASE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_rd_en,
  input wire logic i_wr_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  input wire logic i_start_measure_cmd,
  input wire logic i_locate_cmd,
  input wire logic [4:0] i_location_resistor_pin,
  input wire logic i_location_strap_pin,
  input wire logic i_ext_power,
  input wire logic signed [15:0] i_sense_temp,
  output logic o_converting,
  output logic o_alarm_out,
  output logic o_alarm_oe
);

  typedef enum logic {TSRF_IDLE, TSRF_CONVERT} tsrf_state_t;

  tsrf_state_t state, next_state;
  logic [31:0] conv_cnt, next_conv_cnt;
  logic conv_fmt, next_conv_fmt;
  logic [1:0] conv_res, next_conv_res;
  logic [15:0] temp_result, next_temp_result;
  logic over_limit_flag, next_over_limit_flag;
  logic under_limit_flag, next_under_limit_flag;
  logic [5:0] location, next_location;
  logic [7:0] operating_setup, next_operating_setup;
  logic [15:0] upper_limit, next_upper_limit;
  logic [15:0] lower_limit, next_lower_limit;
  logic cont_active, next_cont_active;
  logic [31:0] base_cnt, next_base_cnt;
  logic [9:0] tick_cnt, next_tick_cnt;
  logic [7:0] rd_data, next_rd_data;
  logic [7:0] map_check_byte;
  logic conv_req;
  logic conv_done;
  logic signed [15:0] result;
  logic [2:0] rate;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] conv_cycles(input logic [1:0] res);
    case (res)
      tsrf_pkg::RES_8: conv_cycles = CONV10_CYCLES >> 2; // [R11]
      tsrf_pkg::RES_9: conv_cycles = CONV10_CYCLES >> 1;
      tsrf_pkg::RES_10: conv_cycles = CONV10_CYCLES;
      default: conv_cycles = CONV10_CYCLES << 2;
    endcase
  endfunction

  function automatic logic [9:0] rate_ticks(input logic [2:0] r);
    case (r)
      3'h1: rate_ticks = tsrf_pkg::TICKS_RATE1;
      3'h2: rate_ticks = tsrf_pkg::TICKS_RATE2;
      3'h3: rate_ticks = tsrf_pkg::TICKS_RATE3;
      3'h4: rate_ticks = tsrf_pkg::TICKS_RATE4;
      3'h5: rate_ticks = tsrf_pkg::TICKS_RATE5;
      3'h6: rate_ticks = tsrf_pkg::TICKS_RATE6;
      default: rate_ticks = tsrf_pkg::TICKS_RATE7;
    endcase
  endfunction

  function automatic logic signed [15:0] shape_result(input logic signed [15:0] raw, input logic fmt,
                                                      input logic [1:0] res);
    logic signed [15:0] v;
    v = raw;
    if (fmt) begin
      if (v > tsrf_pkg::EXTENDED_MAX) v = tsrf_pkg::EXTENDED_MAX; // [R4]
      if (v < tsrf_pkg::EXTENDED_MIN) v = tsrf_pkg::EXTENDED_MIN;
    end else begin
      if (v > tsrf_pkg::NORMAL_MAX) v = tsrf_pkg::NORMAL_MAX; // [R3]
      if (v < tsrf_pkg::NORMAL_MIN) v = tsrf_pkg::NORMAL_MIN;
    end
    case (res)
      tsrf_pkg::RES_8: v = v & 16'shFFF0; // [R10]
      tsrf_pkg::RES_9: v = v & 16'shFFF8;
      tsrf_pkg::RES_10: v = v & 16'shFFFC;
      default: v = v;
    endcase
    shape_result = v;
  endfunction

  assign rate = operating_setup[tsrf_pkg::SETUP_RATE_HI_BIT:tsrf_pkg::SETUP_RATE_LO_BIT];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_conv_fmt = conv_fmt;
    next_conv_res = conv_res;
    next_temp_result = temp_result;
    next_over_limit_flag = over_limit_flag;
    next_under_limit_flag = under_limit_flag;
    next_location = location;
    next_operating_setup = operating_setup;
    next_upper_limit = upper_limit;
    next_lower_limit = lower_limit;
    next_cont_active = cont_active;
    next_base_cnt = base_cnt;
    next_tick_cnt = tick_cnt;
    next_rd_data = rd_data;
    conv_req = 1'b0;
    conv_done = 1'b0;
    result = shape_result(i_sense_temp, conv_fmt, conv_res);

    // automatic rate scheduler
    if (cont_active) begin
      if (base_cnt >= RATE_BASE_CYCLES - 32'h1) begin
        next_base_cnt = 32'h0;
        if (tick_cnt >= rate_ticks(rate) - 10'h1) begin
          next_tick_cnt = 10'h0;
          conv_req = 1'b1; // [R19] [R22]
        end else begin
          next_tick_cnt = tick_cnt + 10'h1;
        end
      end else begin
        next_base_cnt = base_cnt + 32'h1;
      end
    end
    if (i_start_measure_cmd) begin
      conv_req = 1'b1; // [R18]
      next_cont_active = i_ext_power && (rate != 3'h0); // [R19] [R23]
      next_base_cnt = 32'h0;
      next_tick_cnt = 10'h0;
    end

    // conversion sequencer
    case (state)
      TSRF_IDLE: begin
        if (conv_req) begin
          next_state = TSRF_CONVERT;
          next_conv_cnt = conv_cycles(operating_setup[tsrf_pkg::SETUP_RES_HI_BIT:tsrf_pkg::SETUP_RES_LO_BIT]) - 32'h1;
          next_conv_fmt = operating_setup[tsrf_pkg::SETUP_FORMAT_BIT]; // [R5] [R6]
          next_conv_res = operating_setup[tsrf_pkg::SETUP_RES_HI_BIT:tsrf_pkg::SETUP_RES_LO_BIT];
        end
      end
      TSRF_CONVERT: begin
        if (conv_cnt == 32'h0) begin
          conv_done = 1'b1;
          next_state = TSRF_IDLE; // [R18]
          next_temp_result = result; // [R2] [R22]
        end else begin
          next_conv_cnt = conv_cnt - 32'h1;
        end
      end
      default: next_state = TSRF_IDLE;
    endcase

    // limit flags: read clears the latch, a new violation wins over it
    if (i_rd_en && operating_setup[tsrf_pkg::SETUP_INT_MODE_BIT]) begin
      next_over_limit_flag = 1'b0; // [R14]
      next_under_limit_flag = 1'b0;
    end
    if (conv_done) begin
      if (operating_setup[tsrf_pkg::SETUP_INT_MODE_BIT]) begin
        if (result > $signed(upper_limit)) next_over_limit_flag = 1'b1; // [R15] [R24] [R26]
        if (result < $signed(lower_limit)) next_under_limit_flag = 1'b1;
      end else begin
        next_over_limit_flag = result > $signed(upper_limit); // [R12] [R13] [R26]
        next_under_limit_flag = result < $signed(lower_limit);
      end
    end

    // location capture
    if (i_locate_cmd) begin
      next_location = {i_location_strap_pin, i_location_resistor_pin}; // [R9]
    end

    // register writes; bytes 0-2 and 8 ignore writes
    if (i_wr_en) begin
      if (i_addr == tsrf_pkg::ADDR_OPERATING_SETUP) begin
        next_operating_setup = i_wr_data; // [R1]
        next_operating_setup[tsrf_pkg::SETUP_RESERVED_BIT] = 1'b0;
        if (i_wr_data[tsrf_pkg::SETUP_RATE_HI_BIT:tsrf_pkg::SETUP_RATE_LO_BIT] != rate) begin
          next_base_cnt = 32'h0; // [R20]
          next_tick_cnt = 10'h0;
        end
        if (i_wr_data[tsrf_pkg::SETUP_RATE_HI_BIT:tsrf_pkg::SETUP_RATE_LO_BIT] == 3'h0) begin
          next_cont_active = 1'b0; // [R20]
        end
      end else if (i_addr == tsrf_pkg::ADDR_UPPER_LIMIT_HIGH_BYTE) begin
        next_upper_limit[15:8] = i_wr_data; // [R7]
      end else if (i_addr == tsrf_pkg::ADDR_UPPER_LIMIT_LOW_BYTE) begin
        next_upper_limit[7:0] = i_wr_data;
      end else if (i_addr == tsrf_pkg::ADDR_LOWER_LIMIT_LOW_BYTE) begin
        next_lower_limit[7:0] = i_wr_data;
      end else if (i_addr == tsrf_pkg::ADDR_LOWER_LIMIT_HIGH_BYTE) begin
        next_lower_limit[15:8] = i_wr_data;
      end
    end
    if (!i_ext_power) begin
      next_cont_active = 1'b0; // [R23] [R17]
    end

    // read mux
    if (i_rd_en) begin
      if (i_addr == tsrf_pkg::ADDR_TEMP_RESULT_LOW) begin
        next_rd_data = temp_result[7:0]; // [R2]
      end else if (i_addr == tsrf_pkg::ADDR_TEMP_RESULT_HIGH) begin
        next_rd_data = temp_result[15:8];
      end else if (i_addr == tsrf_pkg::ADDR_LIMIT_AND_LOCATION_FLAGS) begin
        next_rd_data = {over_limit_flag, under_limit_flag, location}; // [R8]
      end else if (i_addr == tsrf_pkg::ADDR_OPERATING_SETUP) begin
        next_rd_data = operating_setup;
      end else if (i_addr == tsrf_pkg::ADDR_UPPER_LIMIT_HIGH_BYTE) begin
        next_rd_data = upper_limit[15:8];
      end else if (i_addr == tsrf_pkg::ADDR_UPPER_LIMIT_LOW_BYTE) begin
        next_rd_data = upper_limit[7:0];
      end else if (i_addr == tsrf_pkg::ADDR_LOWER_LIMIT_LOW_BYTE) begin
        next_rd_data = lower_limit[7:0];
      end else if (i_addr == tsrf_pkg::ADDR_LOWER_LIMIT_HIGH_BYTE) begin
        next_rd_data = lower_limit[15:8];
      end else if (i_addr == tsrf_pkg::ADDR_MAP_CHECK_BYTE) begin
        next_rd_data = map_check_byte; // [R25]
      end else begin
        next_rd_data = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= TSRF_IDLE;
      conv_cnt <= 32'h0;
      conv_fmt <= 1'b0;
      conv_res <= tsrf_pkg::RES_12;
      temp_result <= tsrf_pkg::TEMP_RESULT_RESET; // [R1]
      over_limit_flag <= 1'b0; // [R8]
      under_limit_flag <= 1'b0;
      location <= tsrf_pkg::LOCATION_RESET;
      operating_setup <= tsrf_pkg::OPERATING_SETUP_RESET; // [R5] [R10]
      upper_limit <= tsrf_pkg::UPPER_LIMIT_RESET;
      lower_limit <= tsrf_pkg::LOWER_LIMIT_RESET;
      cont_active <= 1'b0;
      base_cnt <= 32'h0;
      tick_cnt <= 10'h0;
      rd_data <= 8'h00;
    end else if (i_clk_en) begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      conv_fmt <= next_conv_fmt;
      conv_res <= next_conv_res;
      temp_result <= next_temp_result;
      over_limit_flag <= next_over_limit_flag;
      under_limit_flag <= next_under_limit_flag;
      location <= next_location;
      operating_setup <= next_operating_setup;
      upper_limit <= next_upper_limit;
      lower_limit <= next_lower_limit;
      cont_active <= next_cont_active;
      base_cnt <= next_base_cnt;
      tick_cnt <= next_tick_cnt;
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // check byte over bytes 0-7
  // ----------------------------------------------------------------
  tsrf_crc8 u_crc (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_map_bytes({lower_limit[15:8], lower_limit[7:0], upper_limit[7:0], upper_limit[15:8],
                  operating_setup, over_limit_flag, under_limit_flag, location,
                  temp_result[15:8], temp_result[7:0]}),
    .o_crc(map_check_byte)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rd_data = rd_data;
  assign o_converting = (state == TSRF_CONVERT);
  assign o_alarm_out = 1'b0;
  assign o_alarm_oe = (over_limit_flag | under_limit_flag) & i_ext_power; // [R16]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_temp_reset_value: assert property (@(posedge i_clk_sys) // [R1]
    $past(i_reset) && !i_reset |-> temp_result == tsrf_pkg::TEMP_RESULT_RESET)
    else $error("temperature not at power-up value after reset");
  a_result_bytes_ro: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R1]
    i_clk_en && !conv_done |=> $stable(temp_result))
    else $error("temperature bytes changed without a conversion end");
  a_setup_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R5]
    i_clk_en && i_wr_en && i_addr == tsrf_pkg::ADDR_OPERATING_SETUP
    |=> operating_setup == ($past(i_wr_data) & 8'hF7))
    else $error("setup write not stored");
  a_comp_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R13]
    i_clk_en && conv_done && !operating_setup[tsrf_pkg::SETUP_INT_MODE_BIT]
    && result <= $signed(upper_limit) && result >= $signed(lower_limit)
    |=> !over_limit_flag && !under_limit_flag)
    else $error("comparator flags not cleared inside limits");
  a_comp_set: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R12]
    i_clk_en && conv_done && result > $signed(upper_limit) |=> over_limit_flag)
    else $error("over-limit flag not set");
  a_int_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R14]
    i_clk_en && operating_setup[tsrf_pkg::SETUP_INT_MODE_BIT] && over_limit_flag && !i_rd_en
    |=> over_limit_flag)
    else $error("latched flag dropped without a read");
  a_single_shot: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R18]
    i_clk_en && conv_done && !cont_active && !i_start_measure_cmd
    |=> state == TSRF_IDLE ##1 (state == TSRF_IDLE || $past(i_start_measure_cmd)))
    else $error("single conversion did not return to shutdown");

  a_rate_stop: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R20]
    i_clk_en && i_wr_en && i_addr == tsrf_pkg::ADDR_OPERATING_SETUP && i_wr_data[2:0] == 3'h0
    |=> !cont_active)
    else $error("writing rate 000 did not stop repeats");

  a_alarm_power: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R16]
    !i_ext_power |-> !o_alarm_oe)
    else $error("alarm driven without external supply");

endmodule // tsrf_core

`default_nettype wire

// ===== tsrf_master_model.sv
/*
  tsrf_master_model: the microcontroller side of the alarm line.
  assumes: the alarm pin is open drain with a pull-up on the board.
*/
`timescale 1ns/10ps
`default_nettype none

module tsrf_master_model (
  input wire logic i_alarm_out,
  input wire logic i_alarm_oe,
  output logic o_alarm_level
);
  // released line floats up to the pull-up level
  assign o_alarm_level = i_alarm_oe ? i_alarm_out : 1'b1;
endmodule // tsrf_master_model

`default_nettype wire

// ===== test_temp_sensor_register_file.sv
/*
  test_temp_sensor_register_file: byte reads and writes, conversions, alarms and rates.
  assumes: tsrf_core with shortened timing (10-bit time 16 cycles, rate base 40 cycles).
*/
`timescale 1ns/10ps
`default_nettype none

module test_temp_sensor_register_file;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic rd_en = 1'b0, wr_en = 1'b0, start = 1'b0, locate = 1'b0, ext_power = 1'b1, strap = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic [4:0] res_pin = 5'h00;
  logic signed [15:0] sense = 16'sh0000;
  logic [7:0] rdat, v, c;
  logic conv, al_out, al_oe, al_lvl;
  logic [7:0] b [8];
  logic [7:0] rv [8] = '{8'h50, 8'h05, 8'h00, 8'h70, 8'h08, 8'h00, 8'h90, 8'hFC};
  logic [15:0] mk [4] = '{16'h0190, 16'h0190, 16'h0194, 16'h0197};
  int nt [4] = '{4, 8, 16, 64};
  int mismatches = 0, cmp_count = 0, cyc = 0, hi, cnt_r;

  always #2 i_clk_sys = ~i_clk_sys;

  tsrf_core #(.CONV10_CYCLES(32'h10), .RATE_BASE_CYCLES(32'h28)) tsrf_core_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(1'b1), .i_rd_en(rd_en), .i_wr_en(wr_en),
    .i_addr(addr), .i_wr_data(wdat), .o_rd_data(rdat), .i_start_measure_cmd(start),
    .i_locate_cmd(locate), .i_location_resistor_pin(res_pin), .i_location_strap_pin(strap),
    .i_ext_power(ext_power), .i_sense_temp(sense), .o_converting(conv), .o_alarm_out(al_out),
    .o_alarm_oe(al_oe));
  tsrf_master_model tsrf_master_model_i (.i_alarm_out(al_out), .i_alarm_oe(al_oe), .o_alarm_level(al_lvl));

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk_sys); wr_en = 1'b1; addr = a; wdat = d;
    @(negedge i_clk_sys); wr_en = 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk_sys); rd_en = 1'b1; addr = a;
    @(negedge i_clk_sys); rd_en = 1'b0; d = rdat;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task strt;
    @(negedge i_clk_sys); start = 1'b1;
    @(negedge i_clk_sys); start = 1'b0;
  endtask
  // one single conversion; hi counts the cycles o_converting stays high
  task cv(input logic signed [15:0] t);
    sense = t;
    strt;
    hi = 0;
    while (conv === 1'b1 && hi < 1000) begin
      @(negedge i_clk_sys); hi++;
    end
  endtask
  // number of conversions seen running in a window of k cycles
  task cnt(input int k);
    logic p;
    p = 1'b0; cnt_r = 0;
    repeat (k) begin
      @(negedge i_clk_sys);
      if (conv === 1'b1 && p !== 1'b1) cnt_r++;
      p = conv;
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] m [8]);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) for (int j = 0; j < 8; j++)
      r = (r >> 1) ^ (((r[0] ^ m[i][j]) == 1'b1) ? tsrf_pkg::CRC_POLY_REFLECTED : 8'h00);
    return r;
  endfunction

  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_reset = 1'b0;
    for (int i = 0; i < 8; i++) rdc(4'(i), rv[i]);
    rdc(4'h9, 8'h00);
    for (int i = 0; i < 3; i++) wr(4'(i), 8'hA5);
    wr(4'h3, 8'h68);
    wr(4'h4, 8'h01);
    for (int i = 0; i < 5; i++) rdc(4'(i), (i == 3) ? 8'h60 : (i == 4) ? 8'h01 : rv[i]);
    $display("test map finished");
    for (int r = 0; r < 4; r++) begin
      wr(4'h3, {1'b0, 2'(r), 5'h00});
      cv(16'sh0197);
      chk(16'(hi), 16'(nt[r]));
      rdc(4'h0, mk[r][7:0]);
      rdc(4'h1, mk[r][15:8]);
    end
    $display("test resolution finished");
    cv(16'sh0900);
    rdc(4'h1, 8'h07);
    rdc(4'h0, 8'hFF);
    rdc(4'h2, 8'h80);
    chk(al_lvl, 1'b0);
    cv(16'shFC00);
    rdc(4'h2, 8'h40);
    cv(16'sh0100);
    rdc(4'h2, 8'h00);
    chk(al_oe, 1'b0);
    for (int i = 0; i < 8; i++) rd(4'(i), b[i]);
    rd(4'h8, c);
    chk(c, crc8(b));
    $display("test comparator finished");
    wr(4'h3, 8'hE0);
    cv(16'sh0900);
    rdc(4'h1, 8'h09);
    rdc(4'h0, 8'h00);
    @(negedge i_clk_sys); locate = 1'b1; res_pin = 5'h15; strap = 1'b1;
    @(negedge i_clk_sys); locate = 1'b0;
    rdc(4'h2, 8'hB5);
    $display("test extended finished");
    wr(4'h3, 8'h70);
    cv(16'sh0200);
    cv(16'sh0000);
    chk(al_oe, 1'b1);
    rdc(4'h2, 8'hB5);
    rdc(4'h2, 8'h35);
    chk(al_oe, 1'b0);
    cv(16'shF000);
    ext_power = 1'b0;
    @(negedge i_clk_sys);
    chk(al_oe, 1'b0);
    ext_power = 1'b1;
    @(negedge i_clk_sys);
    chk(al_oe, 1'b1);
    rdc(4'h2, 8'h75);
    $display("test interrupt finished");
    wr(4'h3, 8'h07);
    sense = 16'sh0100;
    strt;
    cnt(100);
    chk(16'(cnt_r), 16'h0003);
    sense = 16'sh0300;
    cnt(90);
    chk(16'(cnt_r), 16'h0002);
    rdc(4'h1, 8'h03);
    wr(4'h3, 8'h06);
    cnt(170);
    chk(16'(cnt_r), 16'h0002);
    wr(4'h3, 8'h00);
    cnt(100);
    chk(16'(cnt_r), 16'h0000);
    ext_power = 1'b0;
    wr(4'h3, 8'h00);
    cv(16'sh0080);
    chk(16'(hi), 16'h0004);
    rdc(4'h0, 8'h80);
    cnt(190);
    chk(16'(cnt_r), 16'h0000);
    ext_power = 1'b1;
    $display("test rate finished");
    test_done;
  end
endmodule // test_temp_sensor_register_file

`default_nettype wire
